// ==== inc/msfr_pkg.sv ====
// package for the margin, loop scale and frequency register bank
// assumes a command engine delivers decoded command codes and data words
package msfr_pkg;
	// command codes
	localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
	localparam logic [7:0] CMD_SCALE_LOOP = 8'h29;
	localparam logic [7:0] CMD_FREQ_SW = 8'h33;
	// field layout of a linear word
	localparam int EXP_LSB = 11;
	localparam int EXP_W = 5;
	localparam int MANT_W = 11;
	// margin low
	localparam logic [15:0] MARGIN_LOW_RST = 16'h0451;
	localparam int VOUT_EXP = -10;
	// loop scale: exponent -9, mantissa 256, max 512
	localparam logic [4:0] SCALE_EXP = 5'h17;
	localparam logic [10:0] SCALE_MANT_RST = 11'h100;
	localparam logic [10:0] SCALE_MANT_MAX = 11'h200;
	// frequency: exponent 5, six writable mantissa bits, default 19
	localparam logic [4:0] FREQ_EXP = 5'h05;
	localparam logic [5:0] FREQ_MANT_RST = 6'h13;
	localparam int FREQ_STEPS = 14;
	// margin window, percent of nominal
	localparam int MARGIN_PCT = 25;
	// register image carried as one struct
	typedef struct packed {
		logic [15:0] margin_low;
		logic [10:0] scale_mant;
		logic [5:0] freq_mant;
	} msfr_regs_t;
	localparam msfr_regs_t REGS_RST = '{MARGIN_LOW_RST, SCALE_MANT_RST, FREQ_MANT_RST};
	typedef enum logic [1:0] {
		MSFR_OP_NOMINAL = 2'b00,
		MSFR_OP_MARGIN_LOW = 2'b01,
		MSFR_OP_MARGIN_HIGH = 2'b10
	} msfr_op_t;
endpackage

// ==== rtl/msfr_regs.sv ====
// margin low target, loop scale factor and switching frequency registers
// assumes the bus engine runs on i_clk and gives one-cycle command strobes
`timescale 1ns/10ps
module msfr_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// command port from the bus engine
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_cmd,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	output logic o_rvalid,
	// operation state and trim
	input wire logic i_op_load,
	input wire msfr_pkg::msfr_op_t i_op,
	input wire logic [15:0] i_margin_high,
	input wire logic signed [15:0] i_trim,
	// default store interface
	input wire logic i_restore,
	input wire logic i_store,
	input wire msfr_pkg::msfr_regs_t i_nv_image,
	input wire logic i_nv_valid,
	output msfr_pkg::msfr_regs_t o_nv_image,
	output logic o_nv_write,
	// status and applied targets
	output logic o_comm_fault_summary,
	output logic o_invalid_data,
	input wire logic i_status_clear,
	output logic [16:0] o_vout_target,
	output logic [15:0] o_freq_khz
);
	////////////////////////////////////////////////////////////////
	// frequency rounding: step table in kHz
	function automatic logic [15:0] step_khz(input int idx);
		logic [15:0] t [0:13];
		t = '{16'h00C8, 16'h012C, 16'h0190, 16'h01F4, 16'h0258, 16'h02BC, 16'h0320,
			16'h0384, 16'h03E8, 16'h04B0, 16'h0578, 16'h0640, 16'h0708, 16'h076C};
		return t[idx];
	endfunction
	// decoded request in kHz is mant * 2^5
	function automatic logic [5:0] round_freq(input logic [5:0] cur, input logic [10:0] mant);
		logic [15:0] khz;
		logic [5:0] res;
		logic found;
		khz = {mant, 5'h00};
		res = cur;
		found = 1'b0;
		// out of range request leaves the setting alone
		if (khz >= 16'h00C8 && khz <= 16'h07D0) begin
			for (int i = 0; i < msfr_pkg::FREQ_STEPS; i++) begin
				if (!found && step_khz(i) >= khz) begin
					res = 6'(step_khz(i) >> 5);
					found = 1'b1;
				end
			end
			// above 1.9 MHz rounds to the top step
			if (!found) begin
				res = 6'(step_khz(msfr_pkg::FREQ_STEPS - 1) >> 5);
			end
		end
		return res;
	endfunction
	// applied frequency: last table step whose truncated mantissa fits under the stored one
	// keeps the 19 default at 600 kHz instead of the raw 608 that mant * 32 would give
	// limitation: a mantissa below the first step still reports the 200 kHz floor
	function automatic logic [15:0] mant_to_khz(input logic [5:0] mant);
		logic [15:0] khz;
		khz = step_khz(0);
		for (int i = 0; i < msfr_pkg::FREQ_STEPS; i++) begin
			// table is ascending, so the last fit wins
			if (6'(step_khz(i) >> 5) <= mant) begin
				khz = step_khz(i);
			end
		end
		return khz;
	endfunction
	////////////////////////////////////////////////////////////////
	// register image state
	msfr_pkg::msfr_regs_t regs, next_regs;
	logic [15:0] rdata, next_rdata;
	logic rvalid, next_rvalid;
	logic nv_write, next_nv_write;
	msfr_pkg::msfr_regs_t nv_image, next_nv_image;
	// next values of the register image
	always_comb begin
		next_regs = regs;
		next_nv_write = 1'b0;
		next_nv_image = nv_image;
		if (i_restore) begin
			// nonvolatile copy wins over factory reset values when present
			next_regs = i_nv_valid ? i_nv_image : msfr_pkg::REGS_RST;
		end else if (i_wr) begin
			case (i_cmd)
				msfr_pkg::CMD_MARGIN_LOW: begin
					next_regs.margin_low = i_wdata;
				end
				msfr_pkg::CMD_SCALE_LOOP: begin
					// exponent bits dropped, mantissa over 512 refused
					if (i_wdata[10:0] <= msfr_pkg::SCALE_MANT_MAX) begin
						next_regs.scale_mant = i_wdata[10:0];
					end
				end
				msfr_pkg::CMD_FREQ_SW: begin
					// upper five mantissa bits are fixed at zero, so only the low six count
					next_regs.freq_mant = round_freq(regs.freq_mant, {5'h00, i_wdata[5:0]});
				end
				default: begin
					next_regs = regs;
				end
			endcase
		end
		if (i_store) begin
			next_nv_image = regs;
			next_nv_write = 1'b1;
		end
	end
	// read mux: fixed fields rebuilt on every read
	always_comb begin
		next_rvalid = i_rd;
		next_rdata = rdata;
		if (i_rd) begin
			case (i_cmd)
				msfr_pkg::CMD_MARGIN_LOW: next_rdata = regs.margin_low;
				msfr_pkg::CMD_SCALE_LOOP: next_rdata = {msfr_pkg::SCALE_EXP, regs.scale_mant};
				msfr_pkg::CMD_FREQ_SW: next_rdata = {msfr_pkg::FREQ_EXP, 5'h00, regs.freq_mant};
				default: next_rdata = 16'h0000;
			endcase
		end
	end
	// register the image
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			regs <= msfr_pkg::REGS_RST;
			rdata <= 16'h0000;
			rvalid <= 1'b0;
			nv_write <= 1'b0;
			nv_image <= msfr_pkg::REGS_RST;
		end else begin
			regs <= next_regs;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			nv_write <= next_nv_write;
			nv_image <= next_nv_image;
		end
	end
	assign o_rdata = rdata;
	assign o_rvalid = rvalid;
	assign o_nv_write = nv_write;
	assign o_nv_image = nv_image;
	////////////////////////////////////////////////////////////////
	// margin check at operation time
	// nominal in 2^-10 volt: 0.6 V reference / scale = 614.4*512/mant
	logic [31:0] nom;
	logic [31:0] lim_lo, lim_hi;
	logic signed [17:0] req;
	always_comb begin
		// guard against a zero mantissa, which would mean infinite nominal
		nom = (regs.scale_mant == 11'h000) ? 32'h0 : 32'(32'd314573 / {21'h0, regs.scale_mant});
		lim_lo = 32'((nom * 32'(100 - msfr_pkg::MARGIN_PCT)) / 32'd100);
		lim_hi = 32'((nom * 32'(100 + msfr_pkg::MARGIN_PCT)) / 32'd100);
		// commanded value includes trim
		if (i_op == msfr_pkg::MSFR_OP_MARGIN_LOW) begin
			req = 18'($signed({2'b00, regs.margin_low}) + i_trim);
		end else begin
			req = 18'($signed({2'b00, i_margin_high}) + i_trim);
		end
	end
	logic fault, next_fault;
	logic ivd, next_ivd;
	logic [16:0] target, next_target;
	// status flags and applied target
	always_comb begin
		next_fault = fault;
		next_ivd = ivd;
		next_target = target;
		if (i_status_clear) begin
			next_fault = 1'b0;
			next_ivd = 1'b0;
		end
		if (i_op_load) begin
			if (i_op == msfr_pkg::MSFR_OP_NOMINAL) begin
				next_target = 17'(nom);
			end else if (req < $signed({1'b0, lim_lo[16:0]})) begin
				next_fault = 1'b1;
				next_ivd = 1'b1;
				next_target = lim_lo[16:0];
			end else if (req > $signed({1'b0, lim_hi[16:0]})) begin
				next_fault = 1'b1;
				next_ivd = 1'b1;
				next_target = lim_hi[16:0];
			end else begin
				next_target = req[16:0];
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault <= 1'b0;
			ivd <= 1'b0;
			target <= 17'h00000;
		end else begin
			fault <= next_fault;
			ivd <= next_ivd;
			target <= next_target;
		end
	end
	assign o_comm_fault_summary = fault;
	assign o_invalid_data = ivd;
	assign o_vout_target = target;
	// applied frequency follows the stored mantissa
	logic [15:0] freq_khz, next_freq_khz;
	// next applied frequency, snapped to the step table
	always_comb begin
		next_freq_khz = mant_to_khz(regs.freq_mant);
	end
	// register the applied frequency; reset value is the 600 kHz default step
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			freq_khz <= 16'h0258;
		end else begin
			freq_khz <= next_freq_khz;
		end
	end
	assign o_freq_khz = freq_khz;
	////////////////////////////////////////////////////////////////
	// checks
	sequence s_margin_low_req;
		i_op_load && !i_restore && i_op == msfr_pkg::MSFR_OP_MARGIN_LOW;
	endsequence
	// operation load that calls for the margin high state
	sequence s_margin_high_req;
		i_op_load && !i_restore && i_op == msfr_pkg::MSFR_OP_MARGIN_HIGH;
	endsequence
	chk_margin_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && !i_restore && i_cmd == msfr_pkg::CMD_MARGIN_LOW |=> regs.margin_low == $past(i_wdata))
		else $error("margin low write not stored");
	chk_margin_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_margin_low_req and (req < $signed({1'b0, lim_lo[16:0]})) |=> fault && ivd)
		else $error("out of range margin not flagged");
	chk_margin_clamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_margin_low_req and (req < $signed({1'b0, lim_lo[16:0]})) |=> target == $past(lim_lo[16:0]))
		else $error("low margin not clamped");
	chk_margin_use: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_margin_low_req and (req >= $signed({1'b0, lim_lo[16:0]}) && req <= $signed({1'b0, lim_hi[16:0]}))
		|=> target == $past(req[16:0]))
		else $error("margin low target not applied");
	chk_clamp_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_margin_low_req and (req > $signed({1'b0, lim_hi[16:0]})) |=> target == $past(lim_hi[16:0]))
		else $error("high side margin not clamped");
	chk_high_use: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_margin_high_req and (req >= $signed({1'b0, lim_lo[16:0]}) && req <= $signed({1'b0, lim_hi[16:0]}))
		|=> target == $past(req[16:0]))
		else $error("margin high target not applied");
	chk_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_status_clear && !i_op_load |=> !fault && !ivd)
		else $error("status clear did not drop flags");
	chk_restore_nv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_restore && i_nv_valid |=> regs == $past(i_nv_image))
		else $error("restore did not load stored copy");
	chk_restore_def: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_restore && !i_nv_valid |=> regs == msfr_pkg::REGS_RST)
		else $error("restore did not reload defaults");
	chk_store_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_store |=> o_nv_write && o_nv_image == $past(regs))
		else $error("store did not copy registers");
	chk_scale_max: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		regs.scale_mant <= msfr_pkg::SCALE_MANT_MAX)
		else $error("scale mantissa above limit");
	chk_scale_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && !i_restore && i_cmd == msfr_pkg::CMD_SCALE_LOOP && i_wdata[10:0] > msfr_pkg::SCALE_MANT_MAX
		|=> $stable(regs.scale_mant))
		else $error("oversized scale mantissa accepted");
	chk_freq_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && !i_restore && i_cmd == msfr_pkg::CMD_FREQ_SW && (16'({i_wdata[5:0], 5'h00}) < 16'h00C8
		|| 16'({i_wdata[5:0], 5'h00}) > 16'h07D0) |=> $stable(regs.freq_mant))
		else $error("out of range frequency accepted");
	chk_freq_round: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && !i_restore && i_cmd == msfr_pkg::CMD_FREQ_SW && 16'({i_wdata[5:0], 5'h00}) >= 16'h00C8
		&& 16'({i_wdata[5:0], 5'h00}) <= 16'h076C |=> regs.freq_mant >= $past(i_wdata[5:0]))
		else $error("frequency rounded down");
	chk_scale_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_cmd == msfr_pkg::CMD_SCALE_LOOP |=> o_rvalid && o_rdata[15:11] == msfr_pkg::SCALE_EXP)
		else $error("scale exponent wrong on read");
	chk_freq_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		regs.freq_mant >= 6'h06 && regs.freq_mant <= 6'h3B)
		else $error("frequency outside step table");
	chk_read_exp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_cmd == msfr_pkg::CMD_FREQ_SW |=> o_rvalid && o_rdata[15:6] == 10'h0A0)
		else $error("frequency fixed bits wrong on read");
endmodule

// ==== tb/msfr_host.sv ====
// host model that issues command reads and writes to the register bank
// assumes requests are taken on the rising edge of i_clk
`timescale 1ns/10ps
module msfr_host (
	// clock
	input wire logic i_clk,
	// command port toward the bank
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_cmd,
	output logic [15:0] o_wdata,
	input wire logic [15:0] i_rdata,
	input wire logic i_rvalid
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_cmd = 8'h00;
		o_wdata = 16'h0000;
	end
	////////////////////////////////////////////////////////////
	// one word write, then the data lines are scrambled
	task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
		@(negedge i_clk);
		o_cmd = cmd;
		o_wdata = data;
		o_wr = 1'b1;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_wdata = ~data; // stale word must never look valid
	endtask
	// one word read, taken while the valid pulse stands
	task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
		@(negedge i_clk);
		o_cmd = cmd;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
		ok = i_rvalid;
		data = i_rdata;
	endtask
endmodule

// ==== tb/test_margin_scale_frequency_regs.sv ====
// testbench for the margin, scale and frequency register bank
// assumes the host model drives the command port
`timescale 1ns/10ps
module test_margin_scale_frequency_regs;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic wr, rd, op_load, restore, store, nv_valid, st_clr, nv_write, cfs, ivd, rvalid, ok;
	logic [7:0] cmd;
	logic [15:0] wdata, rdata, margin_high, freq_khz, d;
	logic signed [15:0] trim;
	logic [16:0] vout;
	msfr_pkg::msfr_op_t op;
	msfr_pkg::msfr_regs_t nv_in, nv_out;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #5 i_clk = ~i_clk;
	msfr_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(wr), .i_rd(rd), .i_cmd(cmd), .i_wdata(wdata),
		.o_rdata(rdata), .o_rvalid(rvalid), .i_op_load(op_load), .i_op(op), .i_margin_high(margin_high),
		.i_trim(trim), .i_restore(restore), .i_store(store), .i_nv_image(nv_in), .i_nv_valid(nv_valid),
		.o_nv_image(nv_out), .o_nv_write(nv_write), .o_comm_fault_summary(cfs), .o_invalid_data(ivd),
		.i_status_clear(st_clr), .o_vout_target(vout), .o_freq_khz(freq_khz));
	msfr_host host_u (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_cmd(cmd), .o_wdata(wdata), .i_rdata(rdata),
		.i_rvalid(rvalid));
	////////////////////////////////////////////////////////////
	// value compare, wide enough for the stored image
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// read a command and compare word and valid pulse
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		host_u.rd(c, d, ok);
		chk(40'(ok), 40'h1);
		chk(40'(d), 40'(e));
	endtask
	// one strobe cycle on a bench-driven input
	task automatic pulse(ref logic s);
		@(negedge i_clk);
		s = 1'b1;
		@(negedge i_clk);
		s = 1'b0;
	endtask
	// load margin, clear flags, apply operation, check target and flags
	task automatic opchk(input logic [1:0] o, input logic [15:0] ml, input logic [16:0] t, input logic f);
		host_u.wr(8'h26, ml);
		pulse(st_clr);
		op = msfr_pkg::msfr_op_t'(o);
		pulse(op_load);
		chk(40'(vout), 40'(t));
		chk(40'({cfs, ivd}), 40'({f, f}));
	endtask
	// report counts and verdict, end the run
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// hang guard, far beyond the fewer than a hundred cycles of the tests
	initial begin
		#50000;
		n_mismatch++;
		end_sim();
	end
	// main sequence
	initial begin
		{op_load, restore, store, nv_valid, st_clr} = 5'h00;
		op = msfr_pkg::MSFR_OP_NOMINAL;
		trim = 16'sh0000;
		margin_high = 16'h0547;
		nv_in = '{16'h0123, 11'h080, 6'h0A};
		repeat (5) @(negedge i_clk);
		i_rst_n = 1'b1;
		chk(40'(freq_khz), 40'h258);
		rchk(8'h26, 16'h0451);
		rchk(8'h29, 16'hB900);
		rchk(8'h33, 16'h2813);
		rchk(8'h40, 16'h0000);
		host_u.wr(8'h33, 16'hFFD6);
		rchk(8'h33, 16'h2819);
		chk(40'(freq_khz), 40'h320);
		host_u.wr(8'h33, 16'h0005);
		host_u.wr(8'h33, 16'h003F);
		rchk(8'h33, 16'h2819);
		host_u.wr(8'h29, 16'h0201);
		rchk(8'h29, 16'hB900);
		host_u.wr(8'h29, 16'h0200);
		rchk(8'h29, 16'hBA00);
		host_u.wr(8'h29, 16'h0100);
		rchk(8'h29, 16'hB900);
		host_u.wr(8'h26, 16'hFFFF);
		rchk(8'h26, 16'hFFFF);
		opchk(2'd1, 16'h0451, 17'h00451, 1'b0);
		opchk(2'd1, 16'h0000, 17'h00399, 1'b1);
		opchk(2'd1, 16'h07D0, 17'h005FF, 1'b1);
		trim = 16'sd105;
		opchk(2'd1, 16'h03E8, 17'h00451, 1'b0);
		trim = 16'sh0000;
		opchk(2'd2, 16'h0451, 17'h00547, 1'b0);
		opchk(2'd0, 16'h0451, 17'h004CC, 1'b0);
		pulse(store);
		chk(40'(nv_write), 40'h1);
		chk(40'(nv_out), 40'({16'h0451, 11'h100, 6'h19}));
		host_u.wr(8'h26, 16'h1234);
		pulse(restore);
		rchk(8'h26, 16'h0451);
		rchk(8'h33, 16'h2813);
		chk(40'(freq_khz), 40'h258);
		nv_valid = 1'b1;
		pulse(restore);
		rchk(8'h26, 16'h0123);
		rchk(8'h29, 16'hB880);
		rchk(8'h33, 16'h280A);
		end_sim();
	end
endmodule
